/* File: rtl/sclks_regs.svh */
`ifndef SCLKS_REGS_SVH
`define SCLKS_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets on the AXI4-Lite port
`define SCLKS_ADDR_CFG 8'h00
`define SCLKS_ADDR_TRIM_FAST 8'h04
`define SCLKS_ADDR_TRIM_LP 8'h08
`define SCLKS_ADDR_TRIM_TA 8'h0c
`define SCLKS_ADDR_TRIM_TB 8'h10
`define SCLKS_ADDR_STATUS 8'h14
`define SCLKS_ADDR_NVM 8'h18

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define SCLKS_NVM_MODE_LSB 0
`define SCLKS_NVM_STROBE_BIT 2
`define SCLKS_ST_RUN_BIT 0
`define SCLKS_ST_WAKE_BIT 1
`define SCLKS_ST_RDLY_BIT 2
`define SCLKS_ST_BADCODE_BIT 3
`define SCLKS_ST_BADLP_BIT 4
`define SCLKS_ST_SRC_LSB 5

////////////////////////////////////////////////////////////////////////////////
// Reset and shipped values
`define SCLKS_TRIM_RST 8'h00
`define SCLKS_NVM_MODE_RST 2'h0
`define SCLKS_SHIPPED_FUSES 9'h072
`define SCLKS_CODE_EXT 4'h0
`define SCLKS_CODE_FAST 4'h2
`define SCLKS_CODE_LP 4'h4
`define SCLKS_CODE_LFXTAL 4'h6

////////////////////////////////////////////////////////////////////////////////
// Timing: core clock, low-power tick, reset delay, start-up counts
`define SCLKS_CLK_HZ 250000000
`define SCLKS_LP_HZ 32000
`define SCLKS_RST_DELAY_MS 16
`define SCLKS_SU_CK6 16'h0006
`define SCLKS_SU_CK258 16'h0102
`define SCLKS_SU_CK1K 16'h0400
`define SCLKS_SU_CK16K 16384
`define SCLKS_SU_CK32K 32768

`endif

/* File: rtl/sclks_pkg.sv */
package sclks_pkg;

  // Source kinds chosen by the selection code
  typedef enum logic [2:0] {
    SCLKS_SRC_EXT = 3'h0,
    SCLKS_SRC_FAST = 3'h1,
    SCLKS_SRC_LP = 3'h2,
    SCLKS_SRC_LFXTAL = 3'h3,
    SCLKS_SRC_XTAL = 3'h4,
    SCLKS_SRC_NONE = 3'h7
  } sclks_src_t;

  // Sequencer states, Gray along reset delay, run, sleep, wake
  typedef enum logic [1:0] {
    SCLKS_S_RDLY = 2'h0,
    SCLKS_S_RUN = 2'h1,
    SCLKS_S_SLEEP = 2'h3,
    SCLKS_S_WAKE = 2'h2
  } sclks_state_t;

  // Non-volatile configuration bits, raw: one is unprogrammed
  typedef struct packed {
    logic divide_by_eight_default;
    logic startup_time_sel;
    logic [2:0] lowpower_freq_sel;
    logic [3:0] clock_source_code;
  } sclks_fuse_t;

  // Decoded clock selection
  typedef struct packed {
    sclks_src_t src;
    logic [1:0] xtal_band;
    logic [9:0] lowpower_khz;
    logic code_reserved;
    logic lp_reserved;
  } sclks_clk_sel_t;

endpackage

/* File: rtl/sclks_startup_timer.sv */
`timescale 1ns/1ns
`include "sclks_regs.svh"

module sclks_startup_timer #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic start,
  input wire logic [WIDTH-1:0] load_val,
  input wire logic tick,
  // Result
  output logic busy,
  output logic done
);

  logic [WIDTH-1:0] remain; // Ticks still to wait

  ////////////////////////////////////////////////////////////////////////////
  // Count down on ticks; a zero load ends on the next cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      remain <= '0;
      busy <= 1'b0;
    end else if (start) begin
      remain <= load_val;
      busy <= 1'b1;
    end else if (busy && remain == '0) begin
      busy <= 1'b0;
    end else if (busy && tick) begin
      remain <= remain - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One-cycle pulse when the wait ends
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done <= 1'b0;
    end else begin
      done <= busy && !start && remain == '0;
    end
  end

endmodule

/* File: rtl/sclks_top.sv */
// Functional notes
// - Codes pick external, fast, low-power, watch crystal
// - Upper three code bits pick crystal band
// - Configuration bit one unprogrammed, zero programmed
// - Selection bits readable, firmware writes ignored
// - Wake-up timed on selected source, execution held
// - Reset adds delay counted on 32kHz tick
// - Start-up count from code and start-up bit
// - Large frequency steps go through prescaler
// - Reset loads factory fast oscillator trim
// - Fast oscillator trim writable any time
// - Two temperature trim registers for fast oscillator
// - Fast oscillator also times watchdog, reset time-out; code counts both on the 32kHz tick
// - Reset loads factory low-power oscillator trim
// - Three-bit code picks low-power oscillator frequency
// - Watchdog and reset counter stay at 32kHz
// - Shipped: fast oscillator, longest start-up, divide eight
// - Program mode writes ignored while programming pending
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
`include "sclks_regs.svh"

module sclks_top #(
  parameter int LP_DIV = `SCLKS_CLK_HZ / `SCLKS_LP_HZ,
  parameter int SU_CK16K = `SCLKS_SU_CK16K,
  parameter int SU_CK32K = `SCLKS_SU_CK32K,
  parameter int RST_TICKS = `SCLKS_RST_DELAY_MS * `SCLKS_LP_HZ / 1000
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Non-volatile configuration and calibration
  input wire sclks_pkg::sclks_fuse_t nvm_fuse_bits,
  input wire logic [7:0] factory_fast_trim,
  input wire logic [7:0] factory_lowpower_trim,
  input wire logic nvm_program_done,
  // Oscillator output pin, selected source
  input wire logic src_clk_pin,
  // Core power requests
  input wire logic sleep_req,
  input wire logic wake_event,
  // Clock controls out
  output sclks_pkg::sclks_clk_sel_t clk_sel,
  output logic prescale_div8,
  output logic wdt_src_fast,
  output logic wdt_tick,
  output logic cpu_run_en,
  output logic [7:0] fast_osc_trim,
  output logic [7:0] lowpower_osc_trim,
  output logic [7:0] fast_osc_temp_trim_a,
  output logic [7:0] fast_osc_temp_trim_b,
  output logic [1:0] nvm_program_mode,
  output logic nvm_program_strobe
);
  import sclks_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  sclks_fuse_t fuse_q; // Configuration held since reset
  sclks_state_t state; // Sequencer state
  logic [15:0] lp_div_cnt; // 32kHz divider
  logic lp_tick; // 32kHz enable pulse
  logic src_sync1, src_sync2, src_sync3; // Source clock sampling
  logic src_tick; // One pulse per source cycle
  logic [7:0] aw_addr, ar_addr; // Held write address; read address passed straight from the bus
  logic aw_full, w_full; // Held write halves
  logic [31:0] w_data; // Held write data
  logic [3:0] w_strb; // Held byte enables
  logic wr_fire; // Write performed this cycle
  logic wr_b0; // Write hits byte 0
  logic wake_busy, wake_done, rdly_busy, rdly_done;
  logic [15:0] su_count; // Start-up count of the selection

  ////////////////////////////////////////////////////////////////////////////
  // Functions
  // Mapped register offset check, shared by read and write
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a[1:0] == 2'h0) && (a <= `SCLKS_ADDR_NVM);
  endfunction

  // Start-up count for a code and start-up bit; zero for reserved
  function automatic logic [15:0] startup_cycles(input logic [3:0] c, input logic s);
    startup_cycles = 16'h0000;
    if (c == `SCLKS_CODE_EXT || c == `SCLKS_CODE_FAST || c == `SCLKS_CODE_LP) begin
      startup_cycles = s ? 16'h0000 : `SCLKS_SU_CK6;
    end else if (c == `SCLKS_CODE_LFXTAL) begin
      startup_cycles = s ? SU_CK32K[15:0] : `SCLKS_SU_CK1K;
    end else if (c[3] && !c[0]) begin
      startup_cycles = s ? `SCLKS_SU_CK1K : `SCLKS_SU_CK258;
    end else if (c[3]) begin
      startup_cycles = s ? 16'h0000 : SU_CK16K[15:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Configuration capture while reset is held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fuse_q <= nvm_fuse_bits;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Selection decode; zero means programmed
  always_comb begin
    clk_sel = '0;
    clk_sel.src = SCLKS_SRC_NONE;
    clk_sel.xtal_band = fuse_q.clock_source_code[2:1];
    unique case (fuse_q.clock_source_code)
      `SCLKS_CODE_EXT: clk_sel.src = SCLKS_SRC_EXT;
      `SCLKS_CODE_FAST: clk_sel.src = SCLKS_SRC_FAST;
      `SCLKS_CODE_LP: clk_sel.src = SCLKS_SRC_LP;
      `SCLKS_CODE_LFXTAL: clk_sel.src = SCLKS_SRC_LFXTAL;
      4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf: clk_sel.src = SCLKS_SRC_XTAL;
      default: clk_sel.code_reserved = 1'b1;
    endcase
    unique case (fuse_q.lowpower_freq_sel)
      3'h7: clk_sel.lowpower_khz = 10'd32;
      3'h6: clk_sel.lowpower_khz = 10'd64;
      3'h5: clk_sel.lowpower_khz = 10'd128;
      3'h4: clk_sel.lowpower_khz = 10'd256;
      3'h3: clk_sel.lowpower_khz = 10'd512;
      default: clk_sel.lp_reserved = 1'b1;
    endcase
    if (clk_sel.src != SCLKS_SRC_LP) begin
      clk_sel.lowpower_khz = 10'd32;
      clk_sel.lp_reserved = 1'b0;
    end
  end

  // Prescaler divide-by-eight when that bit is programmed
  assign prescale_div8 = !fuse_q.divide_by_eight_default;
  // Fast oscillator keeps timing the watchdog when it is the system clock
  assign wdt_src_fast = (clk_sel.src == SCLKS_SRC_FAST);
  // Watchdog tick stays on 32kHz regardless of low-power frequency
  assign wdt_tick = lp_tick;
  assign su_count = startup_cycles(fuse_q.clock_source_code, fuse_q.startup_time_sel);

  ////////////////////////////////////////////////////////////////////////////
  // 32kHz enable divider
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lp_div_cnt <= '0;
      lp_tick <= 1'b0;
    end else if (lp_div_cnt == LP_DIV[15:0] - 16'h0001) begin
      lp_div_cnt <= '0;
      lp_tick <= 1'b1;
    end else begin
      lp_div_cnt <= lp_div_cnt + 16'h0001;
      lp_tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source clock synchroniser and edge tick; the source must not jump
  // more than 2% per cycle outside reset, else counts are meaningless
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_sync1 <= 1'b0;
      src_sync2 <= 1'b0;
      src_sync3 <= 1'b0;
    end else begin
      src_sync1 <= src_clk_pin;
      src_sync2 <= src_sync1;
      src_sync3 <= src_sync2;
    end
  end
  assign src_tick = src_sync2 && !src_sync3;

  ////////////////////////////////////////////////////////////////////////////
  // Start-up timers: reset delay on 32kHz, wake-up on the source
  sclks_startup_timer #(.WIDTH(16)) u_rdly (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(state == SCLKS_S_RDLY && !rdly_busy && !rdly_done),
    .load_val(RST_TICKS[15:0]),
    .tick(lp_tick),
    .busy(rdly_busy),
    .done(rdly_done)
  );

  sclks_startup_timer #(.WIDTH(16)) u_wake (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(state == SCLKS_S_SLEEP && wake_event),
    .load_val(su_count),
    .tick(src_tick),
    .busy(wake_busy),
    .done(wake_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: reset delay, run, sleep, wake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= SCLKS_S_RDLY;
    end else begin
      unique case (state)
        SCLKS_S_RDLY: begin
          if (rdly_done) begin
            state <= SCLKS_S_RUN;
          end
        end
        SCLKS_S_RUN: begin
          if (sleep_req) begin
            state <= SCLKS_S_SLEEP;
          end
        end
        SCLKS_S_SLEEP: begin
          if (wake_event) begin
            state <= SCLKS_S_WAKE;
          end
        end
        SCLKS_S_WAKE: begin
          if (wake_done) begin
            state <= SCLKS_S_RUN;
          end
        end
      endcase
    end
  end
  assign cpu_run_en = (state == SCLKS_S_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // AXI write channel holding
  assign s_axi_awready = !aw_full;
  assign s_axi_wready = !w_full;
  assign wr_fire = aw_full && w_full && !s_axi_bvalid;
  assign wr_b0 = wr_fire && w_strb[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (s_axi_awvalid && !aw_full) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_full <= 1'b0;
      end
      if (s_axi_wvalid && !w_full) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_full <= 1'b0;
      end
    end
  end

  // Write response, SLVERR for unmapped offsets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= reg_hit(aw_addr) ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trim registers; reset loads factory values into the fast and low-power trims and zero into the temperature trims, writable at any time.
  // Writes to the configuration offset are dropped.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fast_osc_trim <= factory_fast_trim;
      lowpower_osc_trim <= factory_lowpower_trim;
      fast_osc_temp_trim_a <= `SCLKS_TRIM_RST;
      fast_osc_temp_trim_b <= `SCLKS_TRIM_RST;
    end else if (wr_b0) begin
      unique case (aw_addr)
        `SCLKS_ADDR_TRIM_FAST: fast_osc_trim <= w_data[7:0];
        `SCLKS_ADDR_TRIM_LP: lowpower_osc_trim <= w_data[7:0];
        `SCLKS_ADDR_TRIM_TA: fast_osc_temp_trim_a <= w_data[7:0];
        `SCLKS_ADDR_TRIM_TB: fast_osc_temp_trim_b <= w_data[7:0];
        default: ; // Configuration and others ignore writes
      endcase
    end
  end

  // Programming mode and strobe; mode frozen while strobe pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nvm_program_strobe <= 1'b0;
      nvm_program_mode <= `SCLKS_NVM_MODE_RST;
    end else begin
      if (wr_b0 && aw_addr == `SCLKS_ADDR_NVM && !nvm_program_strobe) begin
        nvm_program_mode <= w_data[`SCLKS_NVM_MODE_LSB +: 2];
      end
      if (wr_b0 && aw_addr == `SCLKS_ADDR_NVM && w_data[`SCLKS_NVM_STROBE_BIT]) begin
        nvm_program_strobe <= 1'b1;
      end else if (nvm_program_done) begin
        nvm_program_strobe <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI read channel, one cycle to rvalid
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_addr = s_axi_araddr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= reg_hit(ar_addr) ? 2'h0 : 2'h2;
      s_axi_rdata <= '0;
      unique case (ar_addr)
        `SCLKS_ADDR_CFG: s_axi_rdata[8:0] <= fuse_q;
        `SCLKS_ADDR_TRIM_FAST: s_axi_rdata[7:0] <= fast_osc_trim;
        `SCLKS_ADDR_TRIM_LP: s_axi_rdata[7:0] <= lowpower_osc_trim;
        `SCLKS_ADDR_TRIM_TA: s_axi_rdata[7:0] <= fast_osc_temp_trim_a;
        `SCLKS_ADDR_TRIM_TB: s_axi_rdata[7:0] <= fast_osc_temp_trim_b;
        `SCLKS_ADDR_STATUS: begin
          s_axi_rdata[`SCLKS_ST_RUN_BIT] <= cpu_run_en;
          s_axi_rdata[`SCLKS_ST_WAKE_BIT] <= wake_busy;
          s_axi_rdata[`SCLKS_ST_RDLY_BIT] <= rdly_busy;
          s_axi_rdata[`SCLKS_ST_BADCODE_BIT] <= clk_sel.code_reserved;
          s_axi_rdata[`SCLKS_ST_BADLP_BIT] <= clk_sel.lp_reserved;
          s_axi_rdata[`SCLKS_ST_SRC_LSB +: 3] <= clk_sel.src;
        end
        `SCLKS_ADDR_NVM: begin
          s_axi_rdata[`SCLKS_NVM_MODE_LSB +: 2] <= nvm_program_mode;
          s_axi_rdata[`SCLKS_NVM_STROBE_BIT] <= nvm_program_strobe;
        end
        default: ; // Unmapped reads return zero
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_cfg_held;
    @(posedge aclk) disable iff (!aresetn) $past(aresetn) |-> $stable(fuse_q);
  endproperty
  a_cfg_held: assert property (p_cfg_held) else $error("config changed after reset");

  property p_fast_decode;
    @(posedge aclk) disable iff (!aresetn)
      fuse_q.clock_source_code == `SCLKS_CODE_FAST |-> clk_sel.src == SCLKS_SRC_FAST && wdt_src_fast;
  endproperty
  a_fast_decode: assert property (p_fast_decode) else $error("fast code decode");

  property p_xtal_band;
    @(posedge aclk) disable iff (!aresetn) fuse_q.clock_source_code[3] |->
      clk_sel.src == SCLKS_SRC_XTAL && clk_sel.xtal_band == fuse_q.clock_source_code[2:1];
  endproperty
  a_xtal_band: assert property (p_xtal_band) else $error("crystal band decode");

  property p_wake_hold;
    @(posedge aclk) disable iff (!aresetn)
      state == SCLKS_S_SLEEP && wake_event |=> !cpu_run_en [*3];
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("ran before start-up");

  property p_rst_delay;
    @(posedge aclk) disable iff (!aresetn) !$past(aresetn) |-> !cpu_run_en ##1 !cpu_run_en;
  endproperty
  a_rst_delay: assert property (p_rst_delay) else $error("no reset delay");

  property p_fast_factory;
    @(posedge aclk) disable iff (!aresetn)
      !$past(aresetn) |-> fast_osc_trim == $past(factory_fast_trim);
  endproperty
  a_fast_factory: assert property (p_fast_factory) else $error("factory trim missing");

  property p_trim_write;
    @(posedge aclk) disable iff (!aresetn)
      wr_b0 && aw_addr == `SCLKS_ADDR_TRIM_FAST |=> fast_osc_trim == $past(w_data[7:0]);
  endproperty
  a_trim_write: assert property (p_trim_write) else $error("trim write lost");

  property p_mode_frozen;
    @(posedge aclk) disable iff (!aresetn)
      nvm_program_strobe && wr_b0 && aw_addr == `SCLKS_ADDR_NVM |=> $stable(nvm_program_mode);
  endproperty
  a_mode_frozen: assert property (p_mode_frozen) else $error("mode changed pending");

  property p_lp_freq;
    @(posedge aclk) disable iff (!aresetn) clk_sel.src == SCLKS_SRC_LP &&
      fuse_q.lowpower_freq_sel == 3'h3 |-> clk_sel.lowpower_khz == 10'd512;
  endproperty
  a_lp_freq: assert property (p_lp_freq) else $error("low-power frequency");

  property p_cv_wake;
    @(posedge aclk) disable iff (!aresetn) state == SCLKS_S_WAKE ##1 state == SCLKS_S_RUN;
  endproperty
  c_cv_wake: cover property (p_cv_wake);

  property p_cv_rdly;
    @(posedge aclk) disable iff (!aresetn) rdly_done;
  endproperty
  c_cv_rdly: cover property (p_cv_rdly);

  property p_cv_mode_blocked;
    @(posedge aclk) disable iff (!aresetn)
      nvm_program_strobe && wr_b0 && aw_addr == `SCLKS_ADDR_NVM;
  endproperty
  c_cv_mode_blocked: cover property (p_cv_mode_blocked);

endmodule

/* File: testbench/sclks_osc_model.sv */
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Free-running oscillator seen on the source pin
module sclks_osc_model #(
  parameter int HALF_NS = 10
) (
  // Oscillator output
  output logic osc_out
);
  // Start low; a 1 ns offset keeps pin edges off the core clock edges
  // Fixed period, never a step between cycles
  initial begin
    osc_out = 1'b0;
    #1;
    forever #(HALF_NS) osc_out = ~osc_out;
  end
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  import sclks_pkg::*;
  // Clock, reset, counters
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  int fails = 0;
  int cmp_count = 0;
  // AXI4-Lite master side
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  // Configuration, power requests and outputs
  sclks_fuse_t nvm_fuse_bits = 9'h072;
  logic [7:0] factory_fast_trim = 8'h5a, factory_lowpower_trim = 8'ha5;
  logic nvm_program_done = 1'b0, sleep_req = 1'b0, wake_event = 1'b0;
  wire logic src_clk_pin;
  sclks_clk_sel_t clk_sel;
  logic prescale_div8, wdt_src_fast, wdt_tick, cpu_run_en, nvm_program_strobe;
  logic [7:0] fast_osc_trim, lowpower_osc_trim, fast_osc_temp_trim_a, fast_osc_temp_trim_b;
  logic [1:0] nvm_program_mode;
  // Selection cases: fuse, expected source, expected low-power kHz
  logic [8:0] fz [8] = '{9'h072, 9'h160, 9'h164, 9'h134, 9'h176, 9'h17a, 9'h17f, 9'h171};
  logic [2:0] es [8] = '{3'h1, 3'h0, 3'h2, 3'h2, 3'h3, 3'h4, 3'h4, 3'h7};
  logic [9:0] ek [8] = '{10'h020, 10'h020, 10'h040, 10'h200, 10'h020, 10'h020, 10'h020, 10'h020};
  logic [31:0] d;
  logic [1:0] r;
  int i, n;

  ////////////////////////////////////////////////////////////////////////////////
  // Short counts keep the run brief
  sclks_top #(.LP_DIV(4), .RST_TICKS(3), .SU_CK16K(20), .SU_CK32K(40)) dut (.*);
  sclks_osc_model #(.HALF_NS(10)) osc (.osc_out(src_clk_pin));
  always #2 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Counts, verdict, end of run
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Reset for four clocks with the given fuses
  task automatic do_reset(input logic [8:0] f);
    @(posedge aclk);
    aresetn <= 1'b0;
    nvm_fuse_bits <= f;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  // Write: handshakes sampled before the edge that takes them
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic aw, w, b;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask

  // Read: address held until taken, data taken with rvalid
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ar, rv;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      rv = s_axi_rvalid;
      v = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (rv) begin
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask

  // One-clock pulse on a request line: 0 program done, 1 sleep, 2 wake
  task automatic pulse(input int k);
    @(posedge aclk);
    case (k)
      0: nvm_program_done <= 1'b1;
      1: sleep_req <= 1'b1;
      default: wake_event <= 1'b1;
    endcase
    @(posedge aclk);
    {nvm_program_done, sleep_req, wake_event} <= 3'h0;
  endtask

  // Bounded wait for the core to run
  task automatic wait_run(input int lim);
    for (n = 0; n < lim && cpu_run_en !== 1'b1; n++) @(negedge aclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog on a hung run
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    report_and_stop();
  end

  // Test sequence
  initial begin
    // Selection decode, fuses moved after release must not matter
    for (i = 0; i < 8; i++) begin
      do_reset(fz[i]);
      nvm_fuse_bits <= ~fz[i];
      n = 0;
      repeat (41) begin
        @(negedge aclk);
        if (wdt_tick === 1'b1) n++;
      end
      chk(clk_sel.src, es[i], "source");
      chk(clk_sel.lowpower_khz, ek[i], "lp khz");
      if (es[i] == 3'h4) chk(clk_sel.xtal_band, fz[i][2:1], "band");
      chk(prescale_div8, !fz[i][8], "div8");
      chk(wdt_src_fast, es[i] == 3'h1, "wdt src");
      chk(clk_sel.code_reserved, es[i] == 3'h7, "reserved code");
      chk(n, 32'ha, "wdt ticks");
    end
    $display("test select done");
    // Shipped setting, factory trims, reset delay
    do_reset(9'h072);
    @(negedge aclk);
    chk(fast_osc_trim, 8'h5a, "fast trim");
    chk(lowpower_osc_trim, 8'ha5, "lp trim");
    chk({fast_osc_temp_trim_a, fast_osc_temp_trim_b}, 16'h0, "temp trims");
    repeat (5) @(negedge aclk);
    chk(cpu_run_en, 1'b0, "run early");
    wait_run(40);
    chk(cpu_run_en, 1'b1, "run late");
    $display("test reset done");
    // Configuration readable, writes ignored
    axi_wr(8'h00, 32'h1ff, r);
    chk(r, 2'h0, "cfg resp");
    axi_rd(8'h00, d, r);
    chk(d, 32'h072, "cfg read");
    // Trim registers, upper bits read zero
    for (i = 1; i < 5; i++) begin
      axi_wr(8'(i * 4), 32'hffffff3c + i, r);
      axi_rd(8'(i * 4), d, r);
      chk(d, 32'h3c + i, "trim rw");
    end
    chk(fast_osc_trim, 8'h3d, "trim port");
    // Unmapped place
    axi_wr(8'h1c, 32'h1, r);
    chk(r, 2'h2, "unmapped wr");
    axi_rd(8'h1c, d, r);
    chk(d, 32'h0, "unmapped rd");
    chk(32'(r), 32'h2, "unmapped rresp");
    $display("test registers done");
    // Mode frozen while programming pending
    axi_wr(8'h18, 32'h5, r);
    axi_wr(8'h18, 32'h2, r);
    @(negedge aclk);
    chk({nvm_program_strobe, nvm_program_mode}, 3'h5, "mode held");
    pulse(0);
    axi_wr(8'h18, 32'h2, r);
    @(negedge aclk);
    chk({nvm_program_strobe, nvm_program_mode}, 3'h2, "mode free");
    $display("test nvm done");
    // Sleep and timed wake on the selected source
    pulse(1);
    @(negedge aclk);
    chk(cpu_run_en, 1'b0, "asleep");
    pulse(2);
    repeat (20) @(negedge aclk);
    chk(cpu_run_en, 1'b0, "wake early");
    wait_run(60);
    chk(cpu_run_en, 1'b1, "wake late");
    // Status: running, no timers busy, fast source selected
    axi_rd(8'h14, d, r);
    chk(d, 32'h21, "status");
    $display("test wake done");
    report_and_stop();
  end
endmodule
